// ---- hdl/crer_consts.svh ----
// constants for the cache ram error reporting block
// Summary of operation
// - dirty-data rams (l1d tag/data, l2 tag/data, queue) use secded ecc
// - clean-only rams (l1i tag/data, macro-op, translation cache) use parity
// - one parity bit per word; error fixed by invalidate and refetch
// - ecc check bits computed per protection granule of each ram
// - single-bit error in any ram is corrected, core keeps progressing
// - several single-bit errors in separate rams or granules all corrected
// - ecc double error detected, then reported or deferred
// - parity rams may miss double-bit errors in one word
// - three or more bit errors carry no detection guarantee
// - uncorrectable data carries poison to every consumer
// - l1d tag/data and l2 tag uncorrectables are uncontainable
// - double error on eviction poisons the evicted data
// - outgoing bus data carries a poison attribute
// - barrier takes or pends in deferred status all earlier system errors
// - node 0 records shared l3 errors, node 1 private l1/l2
// - fault raises interrupt and updates detecting node's record
// - fault enable: deferred, uncorrected, counter overflow raise fault irq
// - corrected-fault enable: corrected errors also raise fault irq
// - uncorrected enable: non-deferred uncorrected errors raise error irq
// - consumed error exception chosen from classified error type
// - exceptions are sync abort, async abort or error-recovery interrupt
`ifndef CRER_CONSTS_SVH
`define CRER_CONSTS_SVH
`define CRER_GRAN_W     64
`define CRER_ECC_W      8
`define CRER_CNT_W      8
`define CRER_CNT_RST    8'h00
`define CRER_CNT_MAX    8'hFF
`define CRER_NODE_L3    1'b0
`define CRER_NODE_CORE  1'b1
`define CRER_RAM_W      4
`endif

// ---- hdl/crer_pkg.sv ----
// types for the cache ram error reporting block
package crer_pkg;
    // ram identifiers; below 5 are ecc rams
    typedef enum logic [3:0] {
        CRER_RAM_L1D_DATA = 4'h0,
        CRER_RAM_L1D_TAG  = 4'h1,
        CRER_RAM_L2_DATA  = 4'h2,
        CRER_RAM_L2_TAG   = 4'h3,
        CRER_RAM_QUEUE    = 4'h4,
        CRER_RAM_L1I_DATA = 4'h5,
        CRER_RAM_L1I_TAG  = 4'h6,
        CRER_RAM_MACRO_OP = 4'h7,
        CRER_RAM_TC       = 4'h8
    } crer_ram_e;

    typedef enum logic [1:0] {
        CRER_EXC_NONE         = 2'h0,
        CRER_EXC_SYNC_ABORT   = 2'h1,
        CRER_EXC_ASYNC_ABORT  = 2'h2,
        CRER_EXC_RECOVERY_IRQ = 2'h3
    } crer_exc_e;

    typedef enum logic [1:0] {
        CRER_CLS_OK    = 2'h0,
        CRER_CLS_CE    = 2'h1,
        CRER_CLS_DE    = 2'h2,
        CRER_CLS_UE    = 2'h3
    } crer_cls_e;

    // one ram read presented for checking
    typedef struct packed {
        logic         valid;
        crer_ram_e    ram;
        logic [63:0]  data;
        logic [7:0]   check;
        logic         evict;
        logic         consume;
        logic         sync_use;
        logic         node;
    } crer_rd_s;

    // checked result
    typedef struct packed {
        logic         valid;
        logic [63:0]  data;
        logic         poison;
        logic         refetch;
        crer_cls_e    cls;
    } crer_res_s;

    typedef struct packed {
        logic fault_irq_enable;
        logic corrected_fault_irq_enable;
        logic uncorrected_irq_enable;
    } crer_ctl_s;

    typedef struct packed {
        logic        valid;
        logic        ce;
        logic        de;
        logic        ue;
        logic        uncontain;
        logic        overflow;
        crer_ram_e   ram;
        logic [7:0]  ce_count;
    } crer_rec_s;
endpackage

// ---- hdl/crer_secded.sv ----
// secded decoder for one 64-bit granule, extended hamming 72/64
`timescale 1ns/100ps
module crer_secded
(
    // granule in
    input  wire logic [63:0] i_data,
    input  wire logic [7:0]  i_check,
    // corrected out
    output logic      [63:0] o_data,
    output logic             o_single,
    output logic             o_double
);
    logic [6:0]  syn;
    logic        par;
    logic [7:0]  calc;

    // hamming check bits over data positions, plus overall parity
    function automatic logic [7:0] gen(input logic [63:0] d);
        logic [7:0] c;
        int unsigned p;
        int unsigned k;
        c = 8'h00;
        p = 3;
        for (k = 0; k < 64; k++)
        begin
            while ((p & (p - 1)) == 0)
                p++;
            for (int b = 0; b < 7; b++)
                if (p[b])
                    c[b] ^= d[k];
            p++;
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction

    // map syndrome back to data bit index
    function automatic int pos_to_bit(input logic [6:0] s);
        int unsigned p;
        int r;
        r = -1;
        p = 3;
        for (int k = 0; k < 64; k++)
        begin
            while ((p & (p - 1)) == 0)
                p++;
            if (p[6:0] == s)
                r = k;
            p++;
        end
        return r;
    endfunction

    always_comb
    begin
        int bi;
        bi = -1;
        calc = gen(i_data);
        syn = calc[6:0] ^ i_check[6:0];
        par = ^{i_data, i_check};
        o_data = i_data;
        bi = pos_to_bit(syn);
        o_single = par;
        o_double = (syn != 7'h00) && !par;
        if (par && bi >= 0)
            o_data[bi] = ~i_data[bi];
    end
endmodule // crer_secded

// ---- hdl/crer_top.sv ----
// error checking, containment and reporting for core rams
`timescale 1ns/100ps
`include "crer_consts.svh"
module crer_top
(
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // ram read under check
    input  wire crer_pkg::crer_rd_s    i_rd,
    input  wire logic                  i_parity,
    // error record control and clearing
    input  wire crer_pkg::crer_ctl_s   i_error_record_control,
    input  wire logic                  i_clear_node0,
    input  wire logic                  i_clear_node1,
    // barrier and deferred status
    input  wire logic                  i_error_sync_barrier,
    input  wire logic                  i_serror_pending,
    input  wire logic                  i_serror_taken,
    input  wire logic                  i_deferred_clear,
    // checked result and bus data
    output crer_pkg::crer_res_s        o_res,
    output logic                       o_bus_poison,
    output crer_pkg::crer_exc_e        o_exception,
    // error records
    output crer_pkg::crer_rec_s        o_rec_node0,
    output crer_pkg::crer_rec_s        o_rec_node1,
    output logic                       o_deferred_irq_status_reg,
    // interrupts to the interrupt controller
    output logic                       o_core_fault_irq_out_n,
    output logic                       o_core_error_irq_out_n
);
    import crer_pkg::*;

    logic [63:0] cor_data;
    logic        sgl;
    logic        dbl;
    logic        is_ecc;
    logic        uncont;
    crer_cls_e   cls;

    crer_res_s   res;
    crer_res_s   next_res;
    logic        bus_poison;
    logic        next_bus_poison;
    crer_exc_e   exc;
    crer_exc_e   next_exc;
    crer_rec_s   rec [2];
    crer_rec_s   next_rec [2];
    logic        disr;
    logic        next_disr;
    logic        fault_lat [2];
    logic        next_fault_lat [2];
    logic        err_lat [2];
    logic        next_err_lat [2];

    function automatic logic ram_is_ecc(input crer_ram_e r);
        return r inside {CRER_RAM_L1D_DATA, CRER_RAM_L1D_TAG,
                         CRER_RAM_L2_DATA, CRER_RAM_L2_TAG, CRER_RAM_QUEUE};
    endfunction

    crer_secded u_secded
    (
        .i_data   (i_rd.data),
        .i_check  (i_rd.check),
        .o_data   (cor_data),
        .o_single (sgl),
        .o_double (dbl)
    );

    // classify the current read
    always_comb
    begin
        is_ecc = ram_is_ecc(i_rd.ram);
        uncont = i_rd.ram inside {CRER_RAM_L1D_DATA, CRER_RAM_L1D_TAG,
                                  CRER_RAM_L2_TAG};
        cls = CRER_CLS_OK;
        if (i_rd.valid)
        begin
            if (is_ecc)
            begin
                // double error (nonzero syndrome, even parity): deferred on eviction, else uncorrected
                if (dbl)
                    cls = i_rd.evict ? CRER_CLS_DE : CRER_CLS_UE;
                else if (sgl)
                    cls = CRER_CLS_CE;
            end
            else if (^{i_rd.data, i_parity})
                cls = CRER_CLS_CE;
        end
    end

    // result path
    always_comb
    begin
        next_res.valid   = i_rd.valid;
        next_res.data    = is_ecc ? cor_data : i_rd.data;
        next_res.poison  = i_rd.valid && is_ecc && dbl;
        next_res.refetch = i_rd.valid && !is_ecc
                           && cls == CRER_CLS_CE;
        next_res.cls     = cls;
        next_bus_poison  = next_res.poison && i_rd.evict;
        next_exc = CRER_EXC_NONE;
        if (i_rd.valid && i_rd.consume && dbl && is_ecc)
        begin
            if (uncont && !i_rd.evict)
                next_exc = CRER_EXC_ASYNC_ABORT;
            else if (i_rd.sync_use)
                next_exc = CRER_EXC_SYNC_ABORT;
            else
                next_exc = CRER_EXC_RECOVERY_IRQ;
        end
    end

    // records per node and interrupt levels
    always_comb
    begin
        logic ce;
        logic de;
        logic ue;
        logic ovf;
        logic clr;
        ce = 1'b0;
        de = 1'b0;
        ue = 1'b0;
        ovf = 1'b0;
        clr = 1'b0;
        for (int n = 0; n < 2; n++)
        begin
            next_rec[n] = rec[n];
            next_fault_lat[n] = fault_lat[n];
            next_err_lat[n] = err_lat[n];
            clr = (n == 0) ? i_clear_node0 : i_clear_node1;
            if (clr)
            begin
                next_rec[n] = '0;
                next_fault_lat[n] = 1'b0;
                next_err_lat[n] = 1'b0;
            end
            if (i_rd.valid && cls != CRER_CLS_OK
                && i_rd.node == n[0])
            begin
                ce  = cls == CRER_CLS_CE;
                de  = cls == CRER_CLS_DE;
                ue  = cls == CRER_CLS_UE;
                ovf = ce && !clr && rec[n].ce_count == `CRER_CNT_MAX;
                next_rec[n].valid     = 1'b1;
                next_rec[n].ram       = i_rd.ram;
                next_rec[n].ce        = next_rec[n].ce | ce;
                next_rec[n].de        = next_rec[n].de | de;
                next_rec[n].ue        = next_rec[n].ue | ue;
                next_rec[n].uncontain = next_rec[n].uncontain
                                        | (ue && uncont);
                next_rec[n].overflow  = next_rec[n].overflow | ovf;
                if (ce)
                    next_rec[n].ce_count = clr ? 8'h01
                                         : rec[n].ce_count + 8'h01;
                if (i_error_record_control.fault_irq_enable
                    && (de || ue || ovf))
                    next_fault_lat[n] = 1'b1;
                if (i_error_record_control.corrected_fault_irq_enable
                    && ce)
                    next_fault_lat[n] = 1'b1;
                if (i_error_record_control.uncorrected_irq_enable && ue)
                    next_err_lat[n] = 1'b1;
            end
        end
    end

    // deferred system-error status at barrier
    always_comb
    begin
        next_disr = disr;
        if (i_deferred_clear)
            next_disr = 1'b0;
        if (i_error_sync_barrier && i_serror_pending && !i_serror_taken)
            next_disr = 1'b1;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            res        <= '0;
            bus_poison <= 1'b0;
            exc        <= CRER_EXC_NONE;
            disr       <= 1'b0;
            for (int n = 0; n < 2; n++)
            begin
                rec[n]       <= '0;
                fault_lat[n] <= 1'b0;
                err_lat[n]   <= 1'b0;
            end
        end
        else
        begin
            res        <= next_res;
            bus_poison <= next_bus_poison;
            exc        <= next_exc;
            disr       <= next_disr;
            for (int n = 0; n < 2; n++)
            begin
                rec[n]       <= next_rec[n];
                fault_lat[n] <= next_fault_lat[n];
                err_lat[n]   <= next_err_lat[n];
            end
        end
    end

    assign o_res                     = res;
    assign o_bus_poison              = bus_poison;
    assign o_exception               = exc;
    assign o_rec_node0               = rec[0];
    assign o_rec_node1               = rec[1];
    assign o_deferred_irq_status_reg = disr;
    assign o_core_fault_irq_out_n    = ~(fault_lat[0] | fault_lat[1]);
    assign o_core_error_irq_out_n    = ~(err_lat[0] | err_lat[1]);
endmodule // crer_top

// ---- verif/crer_irq_ctrl.sv ----
// interrupt controller model: notes each active-low irq it receives
`timescale 1ns/100ps
module crer_irq_ctrl
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // irq lines from the core
    input  wire logic i_fault_n,
    input  wire logic i_error_n,
    // sticky seen flags
    output logic      o_fault_seen,
    output logic      o_error_seen
);
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_fault_seen <= 1'b0;
            o_error_seen <= 1'b0;
        end
        else
        begin
            o_fault_seen <= o_fault_seen | ~i_fault_n;
            o_error_seen <= o_error_seen | ~i_error_n;
        end
    end
endmodule // crer_irq_ctrl

// ---- verif/crer_top_asserts.sv ----
// concurrent checks on the error reporting block ports
`timescale 1ns/100ps
module crer_top_asserts
    import crer_pkg::*;
(
    // clock, reset and inputs
    input wire logic                i_clk,
    input wire logic                i_rst,
    input wire crer_pkg::crer_rd_s  i_rd,
    input wire logic                i_parity,
    input wire crer_pkg::crer_ctl_s i_error_record_control,
    input wire logic                i_clear_node0,
    input wire logic                i_clear_node1,
    input wire logic                i_error_sync_barrier,
    input wire logic                i_serror_pending,
    input wire logic                i_serror_taken,
    input wire logic                i_deferred_clear,
    // design outputs
    input wire crer_pkg::crer_res_s o_res,
    input wire logic                o_bus_poison,
    input wire crer_pkg::crer_exc_e o_exception,
    input wire crer_pkg::crer_rec_s o_rec_node0,
    input wire crer_pkg::crer_rec_s o_rec_node1,
    input wire logic                o_deferred_irq_status_reg,
    input wire logic                o_core_fault_irq_out_n,
    input wire logic                o_core_error_irq_out_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    logic bad;
    assign bad = o_res.valid && o_res.cls inside {CRER_CLS_DE, CRER_CLS_UE};
    chk_bad_poison: assert property (
        bad |-> o_res.poison) else $error("bad data not poisoned");
    chk_bus_poison: assert property (
        o_res.valid |-> o_bus_poison == (o_res.poison && $past(i_rd.evict)))
        else $error("bus poison wrong");
    chk_de_evict: assert property (
        o_res.valid && o_res.cls == CRER_CLS_DE |-> $past(i_rd.evict))
        else $error("deferred without eviction");
    chk_ue_err_irq: assert property (
        o_res.valid && o_res.cls == CRER_CLS_UE
        && $past(i_error_record_control.uncorrected_irq_enable)
        |-> !o_core_error_irq_out_n) else $error("error irq missing");
    chk_bad_fault_irq: assert property (
        bad && $past(i_error_record_control.fault_irq_enable)
        |-> !o_core_fault_irq_out_n) else $error("fault irq missing");
    chk_ce_fault_irq: assert property (
        o_res.valid && o_res.cls == CRER_CLS_CE
        && $past(i_error_record_control.corrected_fault_irq_enable)
        |-> !o_core_fault_irq_out_n) else $error("ce fault irq missing");
    chk_irq_hold: assert property (
        !o_core_error_irq_out_n && !i_clear_node0 && !i_clear_node1
        |=> !o_core_error_irq_out_n) else $error("error irq dropped");
    chk_irq_clear: assert property (
        i_clear_node0 && i_clear_node1 && !i_rd.valid
        |=> o_core_error_irq_out_n && o_core_fault_irq_out_n)
        else $error("irq not released");
    chk_refetch_ram: assert property (
        o_res.valid && o_res.refetch
        |-> o_res.cls == CRER_CLS_CE && $past(i_rd.ram) >= CRER_RAM_L1I_DATA)
        else $error("refetch on wrong ram");
    chk_exc_cause: assert property (
        o_exception != CRER_EXC_NONE |-> $past(i_rd.valid && i_rd.consume))
        else $error("exception without consumed read");
    cov_ue: cover property (o_res.valid && o_res.cls == CRER_CLS_UE);
    cov_de: cover property (o_res.valid && o_res.cls == CRER_CLS_DE);
    cov_refetch: cover property (o_res.valid && o_res.refetch);
endmodule // crer_top_asserts

bind crer_top crer_top_asserts i_crer_top_asserts (
    .i_clk(i_clk), .i_rst(i_rst), .i_rd(i_rd), .i_parity(i_parity),
    .i_error_record_control(i_error_record_control),
    .i_clear_node0(i_clear_node0), .i_clear_node1(i_clear_node1),
    .i_error_sync_barrier(i_error_sync_barrier),
    .i_serror_pending(i_serror_pending), .i_serror_taken(i_serror_taken),
    .i_deferred_clear(i_deferred_clear), .o_res(o_res),
    .o_bus_poison(o_bus_poison), .o_exception(o_exception),
    .o_rec_node0(o_rec_node0), .o_rec_node1(o_rec_node1),
    .o_deferred_irq_status_reg(o_deferred_irq_status_reg),
    .o_core_fault_irq_out_n(o_core_fault_irq_out_n),
    .o_core_error_irq_out_n(o_core_error_irq_out_n));

// ---- verif/crer_top_tb_top.sv ----
// self-checking bench for the cache ram error reporting block
`timescale 1ns/100ps
module crer_top_tb_top;
    import crer_pkg::*;
    localparam logic [63:0] D0 = 64'hA5C3_0F96_1E2D_3C4B;
    logic i_clk, i_rst, i_parity, clr, bar, pend, taken, dclr, node;
    logic bus_poison, dstat, fault_n, error_n, fault_seen, error_seen;
    crer_rd_s  i_rd;
    crer_ctl_s ctl;
    crer_res_s res;
    crer_exc_e exc;
    crer_rec_s rec0, rec1;
    int        num_errors, samples_checked, cycles;
    crer_top i_crer_top (.i_clk(i_clk), .i_rst(i_rst), .i_rd(i_rd),
        .i_parity(i_parity), .i_error_record_control(ctl),
        .i_clear_node0(clr), .i_clear_node1(clr),
        .i_error_sync_barrier(bar), .i_serror_pending(pend),
        .i_serror_taken(taken), .i_deferred_clear(dclr), .o_res(res),
        .o_bus_poison(bus_poison), .o_exception(exc), .o_rec_node0(rec0),
        .o_rec_node1(rec1), .o_deferred_irq_status_reg(dstat),
        .o_core_fault_irq_out_n(fault_n), .o_core_error_irq_out_n(error_n));
    crer_irq_ctrl i_crer_irq_ctrl (.i_clk(i_clk), .i_rst(i_rst),
        .i_fault_n(fault_n), .i_error_n(error_n),
        .o_fault_seen(fault_seen), .o_error_seen(error_seen));
    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // extended hamming: data at non-power-of-two positions from 3
    function automatic logic [7:0] ecc(input logic [63:0] d);
        logic [7:0] c;
        int p;
        c = 8'h00;
        p = 3;
        for (int k = 0; k < 64; k++)
        begin
            while ((p & (p - 1)) == 0) p++;
            for (int i = 0; i < 7; i++) if (p[i]) c[i] ^= d[k];
            p++;
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask
    // f holds evict, consume, sync_use
    task automatic rd(input int ram, input logic [63:0] flip,
                      input logic [2:0] f);
        i_rd = '{1'b1, crer_ram_e'(ram), D0 ^ flip, ecc(D0),
                 f[2], f[1], f[0], node};
        i_parity = ^D0;
        tick();
    endtask
    task automatic clear;
        i_rd.valid = 1'b0;
        clr = 1'b1;
        tick();
        clr = 1'b0;
        chk({fault_n, error_n, rec0.valid, rec1.valid}, 4'hC);
    endtask
    task automatic t_ecc_rams;
        ctl = 3'b010;
        node = 1'b1;
        chk({fault_seen, error_seen}, 2'h0);
        for (int r = 0; r < 5; r++)
        begin
            rd(r, 64'h1 << (r * 13), 3'b000);
            chk(res.data, D0);
            chk({res.cls, fault_n, error_n}, 4'h5);
        end
        chk({rec1.ce, rec1.ram, rec1.ce_count}, 13'h1405);
        chk(fault_seen, 1'b1);
        rd(2, 64'h0, 3'b000);
        chk({res.valid, res.cls, res.poison}, 4'h8);
        clear();
    endtask
    task automatic t_parity;
        ctl = 3'b000;
        for (int r = 5; r < 9; r++)
        begin
            rd(r, 64'h1 << r, 3'b000);
            chk({res.cls, res.refetch, res.poison}, 4'h6);
        end
        rd(7, 64'h0, 3'b000);
        chk({res.cls, res.refetch}, 3'h0);
        clear();
    endtask
    task automatic t_ue;
        ctl = 3'b001;
        chk(error_seen, 1'b0);
        rd(2, 64'h3, 3'b010);
        chk({res.cls, res.poison, exc}, 5'h1F);
        chk({error_n, fault_n, rec1.ue}, 3'h3);
        repeat (2) tick();
        chk({error_n, error_seen}, 2'h1);
        clear();
    endtask
    task automatic t_de;
        ctl = 3'b100;
        node = 1'b0;
        rd(0, 64'h81, 3'b100);
        chk({res.cls, bus_poison, fault_n, error_n}, 5'h15);
        chk({rec0.de, rec1.valid}, 2'h2);
        clear();
    endtask
    task automatic t_exc;
        node = 1'b1;
        rd(1, 64'h6, 3'b010);
        chk({exc, rec1.uncontain}, 3'h5);
        rd(3, 64'h6, 3'b010);
        chk({exc, rec1.uncontain}, 3'h5);
        rd(2, 64'h6, 3'b011);
        chk(exc, CRER_EXC_SYNC_ABORT);
        clear();
    endtask
    task automatic t_overflow;
        ctl = 3'b100;
        repeat (255) rd(2, 64'h10, 3'b000);
        chk({rec1.ce_count, rec1.overflow, fault_n}, 10'h3FD);
        rd(2, 64'h10, 3'b000);
        chk({rec1.overflow, fault_n}, 2'h2);
        clear();
    endtask
    task automatic t_barrier;
        pend = 1'b1;
        bar = 1'b1;
        tick();
        bar = 1'b0;
        tick();
        chk(dstat, 1'b1);
        dclr = 1'b1;
        taken = 1'b1;
        tick();
        dclr = 1'b0;
        bar = 1'b1;
        tick();
        bar = 1'b0;
        pend = 1'b0;
        chk(dstat, 1'b0);
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            print_verdict();
        end
    end
    initial
    begin
        {i_rst, i_parity, clr, bar, pend, taken, dclr, node} = 8'h80;
        i_rd = '0;
        ctl = '0;
        num_errors = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (12) @(posedge i_clk);
        #1 i_rst = 1'b0;
        t_ecc_rams();
        t_parity();
        t_ue();
        t_de();
        t_exc();
        t_overflow();
        t_barrier();
        print_verdict();
    end
endmodule // crer_top_tb_top
